// ---- common/dmau_defs.svh ----
// Constants for the data memory addressing unit: offsets, indices, patterns and counts.
`ifndef DMAU_DEFS_SVH
`define DMAU_DEFS_SVH

// ****************************************************************
// Special register offsets within sector 0.
// ****************************************************************
`define DMAU_OFF_IND0       8'h00
`define DMAU_OFF_PTR0       8'h01
`define DMAU_OFF_IND1       8'h02
`define DMAU_OFF_PTR1L      8'h03
`define DMAU_OFF_PTR1H      8'h04
`define DMAU_OFF_IND2       8'h05
`define DMAU_OFF_PTR2L      8'h06
`define DMAU_OFF_PTR2H      8'h07
`define DMAU_OFF_PCL        8'h08
`define DMAU_OFF_TABLE_POINTER_LOW       8'h09
`define DMAU_OFF_TABLE_POINTER_HIGH       8'h0a
`define DMAU_OFF_TABLE_HIGH_LATCH       8'h0b
`define DMAU_OFF_UNLOCK     8'h68
`define DMAU_SECTOR_ZERO    2'h0

// ****************************************************************
// Indices into the stored register array.
// ****************************************************************
`define DMAU_IDX_PTR0       3'h0
`define DMAU_IDX_PTR1L      3'h1
`define DMAU_IDX_PTR1H      3'h2
`define DMAU_IDX_PTR2L      3'h3
`define DMAU_IDX_PTR2H      3'h4
`define DMAU_IDX_TABLE_POINTER_LOW       3'h5
`define DMAU_IDX_TABLE_POINTER_HIGH       3'h6
`define DMAU_IDX_UNLOCK     3'h7
`define DMAU_NUM_STORED     8

// ****************************************************************
// Reset values, unlock pattern, option map layout and timing.
// ****************************************************************
`define DMAU_REG_RESET      8'h00
`define DMAU_READ_ZERO      8'h00
`define DMAU_PATTERN_FIRST  8'h55
`define DMAU_PATTERN_SECOND 8'haa
`define DMAU_OPT_BASE       8'hc0
`define DMAU_LAST_PAGE      5'h1f
`define DMAU_LOW_SPEED_INTERNAL_OSC_PERIODS   3'h4

`endif

// ---- common/dmau_pkg.sv ----
// Types shared by the data memory addressing unit.
package dmau_pkg;

	// Table read sequencer states.
	typedef enum logic [0:0] {
		TBL_IDLE  = 1'b0,
		TBL_FETCH = 1'b1
	} dmau_tbl_state_type;

endpackage : dmau_pkg

// ---- sim/dmau_mem_model.sv ----
// Behavioural data RAM, program memory and option memory beside the unit.
`timescale 1ns/1ps

module dmau_mem_model (
	// Clock.
	input  wire logic        clk_i,
	// Data RAM port.
	input  wire logic [9:0]  ram_addr_i,
	input  wire logic        ram_rd_i,
	output logic      [7:0]  ram_rdata_o = 8'h3c,
	// Program memory port.
	input  wire logic [12:0] pm_addr_i,
	input  wire logic        pm_rd_i,
	output logic      [15:0] pm_rdata_o,
	// Option memory port.
	input  wire logic [5:0]  opt_addr_i,
	input  wire logic        opt_rd_i,
	output logic      [15:0] opt_rdata_o
);
	// ****
	// Answers
	// ****
	// RAM data is good only in the cycle after a fetch; it flips otherwise so stale data never passes.
	always @(posedge clk_i) begin
		ram_rdata_o <= ram_rd_i ? (ram_addr_i[7:0] ^ {6'h15, ram_addr_i[9:8]}) : ~ram_rdata_o;
	end

	// Program and option words answer while the fetch strobe stands, and show the inverse otherwise.
	always_comb begin
		pm_rdata_o  = pm_rd_i ? {~pm_addr_i[7:0], 3'h0, pm_addr_i[12:8]} :
		              ~{~pm_addr_i[7:0], 3'h0, pm_addr_i[12:8]};
		opt_rdata_o = opt_rd_i ? {2'h3, opt_addr_i, 2'h0, ~opt_addr_i} :
		              ~{2'h3, opt_addr_i, 2'h0, ~opt_addr_i};
	end
endmodule : dmau_mem_model

// ---- sim/test_data_memory_addressing_unit.sv ----
// Self-checking bench for the data memory addressing unit.
`timescale 1ns/1ps
`include "dmau_defs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
	$display("wrong value at %0t: %h versus %h", $time, g, e); end end

module test_data_memory_addressing_unit;
	// ****
	// Signals
	// ****
	// Stimulus, observed outputs and bench state.
	logic        clk = 1'b0, rst = 1'b1, stb = 1'b0, wake = 1'b0, low_speed_internal_osc = 1'b0;
	logic        rd = 1'b0, wr = 1'b0, trd = 1'b0, tlast = 1'b0;
	logic [9:0]  addr = 10'h000, ra, a, pw, last_ra, last_wa;
	logic [7:0]  wdat = 8'h00, program_counter_low_byte = 8'h00, rdat, rwd, rrd, jlow, tlow, got, tp, th, last_wd;
	logic        rvld, rr, rw, jmp, dmy, tdone, prd, ord, act;
	logic [12:0] pa;
	logic [5:0]  oa;
	logic [15:0] pd, od;
	logic [31:0] v, seed = 32'h36;
	int          i, p, t0, cyc = 0, nwr = 0, n0, fails = 0, tests_run = 0;
	logic [7:0]  roff [9] = '{`DMAU_OFF_PTR0, `DMAU_OFF_PTR1L, `DMAU_OFF_PTR1H, `DMAU_OFF_PTR2L,
		`DMAU_OFF_PTR2H, `DMAU_OFF_TABLE_POINTER_LOW, `DMAU_OFF_TABLE_POINTER_HIGH, `DMAU_OFF_TABLE_HIGH_LATCH, `DMAU_OFF_UNLOCK};
	logic [7:0]  pt [4] = '{`DMAU_OFF_IND0, `DMAU_OFF_IND1, `DMAU_OFF_IND2, 8'h00};
	logic [7:0]  lo [4] = '{`DMAU_OFF_PTR0, `DMAU_OFF_PTR1L, `DMAU_OFF_PTR2L, 8'h00};
	logic [7:0]  se [4] = '{8'h00, `DMAU_OFF_PTR1H, `DMAU_OFF_PTR2H, 8'h00};

	// Clock and a slow oscillator of unrelated phase.
	always #25 clk = ~clk;
	always #803 low_speed_internal_osc = ~low_speed_internal_osc;

	// ****
	// Instances
	// ****
	// Unit under test and its memories.
	dmau_top dut (.CLK_I(clk), .RESET_I(rst), .INSTR_STROBE_I(stb), .WAKE_I(wake),
		.DM_ADDR_I(addr), .DM_RD_I(rd), .DM_WR_I(wr), .DM_WDATA_I(wdat),
		.DM_RDATA_O(rdat), .DM_RVALID_O(rvld), .RAM_ADDR_O(ra), .RAM_RD_O(rr),
		.RAM_WR_O(rw), .RAM_WDATA_O(rwd), .RAM_RDATA_I(rrd), .PC_LOW_I(program_counter_low_byte),
		.JUMP_O(jmp), .JUMP_LOW_O(jlow), .DUMMY_CYCLE_O(dmy), .TBL_RD_I(trd),
		.TBL_LAST_PAGE_I(tlast), .TBL_LOW_O(tlow), .TBL_DONE_O(tdone), .PM_ADDR_O(pa),
		.PM_RD_O(prd), .PM_RDATA_I(pd), .OPT_ADDR_O(oa), .OPT_RD_O(ord),
		.OPT_RDATA_I(od), .LOW_SPEED_INTERNAL_OSC_I(low_speed_internal_osc), .MAP_ACTIVE_O(act));
	dmau_mem_model mem (.clk_i(clk), .ram_addr_i(ra), .ram_rd_i(rr), .ram_rdata_o(rrd),
		.pm_addr_i(pa), .pm_rd_i(prd), .pm_rdata_o(pd), .opt_addr_i(oa),
		.opt_rd_i(ord), .opt_rdata_o(od));

	// Logs RAM traffic away from the clock edge.
	always @(negedge clk) begin
		if (rr === 1'b1) last_ra <= ra;
		if (rw === 1'b1) begin
			last_wa <= ra;
			last_wd <= rwd;
			nwr <= nwr + 1;
		end
	end

	// Cuts a hang short.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fails++;
			wrap_up();
		end
	end

	// ****
	// Helpers
	// ****
	// Xorshift source of repeatable random values.
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	// Content that the RAM holds at an address.
	function automatic logic [7:0] ramf(input logic [9:0] x);
		return x[7:0] ^ {6'h15, x[9:8]};
	endfunction : ramf

	// Drives one instruction cycle of the core.
	task put(input logic s, r, w, input logic [9:0] x, input logic [7:0] d);
		@(posedge clk);
		stb <= s;
		rd <= r;
		wr <= w;
		addr <= x;
		wdat <= d;
	endtask : put

	// Writes one location.
	task wrt(input logic [9:0] x, input logic [7:0] d);
		put(1, 0, 1, x, d);
		put(0, 0, 0, x, d);
	endtask : wrt

	// Reads one location and waits a bounded time for the answer.
	task rdv(input logic [9:0] x, output logic [7:0] d);
		int k;
		put(1, 1, 0, x, 8'h00);
		put(0, 0, 0, x, 8'h00);
		for (k = 0; k < 4 && rvld !== 1'b1; k++) @(negedge clk);
		`CHK(rvld, 1'b1)
		d = rdat;
	endtask : rdv

	// Unlock pattern, optionally with an idle instruction cycle between.
	task unl(input logic [7:0] d2, input logic gap);
		put(1, 0, 1, {2'h0, `DMAU_OFF_UNLOCK}, `DMAU_PATTERN_FIRST);
		if (gap) put(1, 0, 0, 10'h000, 8'h00);
		put(1, 0, 1, {2'h0, `DMAU_OFF_UNLOCK}, d2);
		put(0, 0, 0, 10'h000, 8'h00);
		repeat (3) @(negedge clk);
	endtask : unl

	// Table read at the current pointers, checked against memory contents.
	task tbx(input logic last, input logic opt);
		logic [12:0] q;
		logic [15:0] w;
		q = {last ? `DMAU_LAST_PAGE : th[4:0], tp};
		w = opt ? {2'h3, tp[5:0], 2'h0, ~tp[5:0]} : {~q[7:0], 3'h0, q[12:8]};
		@(posedge clk);
		trd <= 1'b1;
		tlast <= last;
		@(posedge clk);
		trd <= 1'b0;
		@(negedge clk);
		if (opt) `CHK({prd, ord, oa}, {2'b01, tp[5:0]})
		else `CHK({prd, ord, pa}, {2'b10, q})
		@(negedge clk);
		`CHK({tdone, tlow}, {1'b1, w[7:0]})
		rdv({2'h0, `DMAU_OFF_TABLE_HIGH_LATCH}, got);
		`CHK(got, w[15:8])
	endtask : tbx

	// Prints the verdict and ends the run.
	task wrap_up();
		if (fails == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up

	// ****
	// Main sequence
	// ****
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		for (i = 0; i < 9; i++) begin
			rdv({2'h0, roff[i]}, got);
			`CHK(got, `DMAU_REG_RESET)
		end
		for (i = 0; i < 14; i++) begin
			v = xs();
			wrt({2'h0, roff[i % 7]}, v[7:0]);
			rdv({2'h0, roff[i % 7]}, got);
			`CHK(got, v[7:0])
		end
		wrt({2'h0, `DMAU_OFF_TABLE_HIGH_LATCH}, 8'hff);
		rdv({2'h0, `DMAU_OFF_TABLE_HIGH_LATCH}, got);
		`CHK(got, `DMAU_REG_RESET)
		// A pointer aimed at its own port.
		wrt({2'h0, `DMAU_OFF_PTR0}, `DMAU_OFF_IND0);
		rdv({2'h0, `DMAU_OFF_IND0}, got);
		`CHK(got, `DMAU_READ_ZERO)
		n0 = nwr;
		wrt({2'h0, `DMAU_OFF_IND0}, 8'h77);
		repeat (2) @(negedge clk);
		`CHK(nwr, n0)
		// Indirect through each port, and direct extended accesses.
		for (i = 0; i < 16; i++) begin
			p = i % 4;
			v = xs();
			a = {p == 0 ? 2'h0 : v[9:8], 1'b1, v[6:0]};
			pw = (p == 3) ? a : {2'h0, pt[p]};
			if (p != 3) wrt({2'h0, lo[p]}, a[7:0]);
			if (p == 1 || p == 2) wrt({2'h0, se[p]}, {v[15:10], a[9:8]});
			wrt(pw, v[23:16]);
			rdv(pw, got);
			`CHK({last_wa, last_wd}, {a, v[23:16]})
			`CHK({last_ra, got}, {a, ramf(a)})
		end
		// Program counter low byte read and jump.
		v = xs();
		@(posedge clk);
		program_counter_low_byte <= v[7:0];
		rdv({2'h0, `DMAU_OFF_PCL}, got);
		`CHK(got, v[7:0])
		wrt({2'h0, `DMAU_OFF_PCL}, v[15:8]);
		@(negedge clk);
		`CHK({jmp, jlow, dmy}, {1'b1, v[15:8], 1'b0})
		@(negedge clk);
		`CHK({jmp, dmy}, 2'b01)
		// Table reads from program memory.
		for (i = 0; i < 4; i++) begin
			v = xs();
			tp = v[7:0];
			th = v[15:8];
			wrt({2'h0, `DMAU_OFF_TABLE_POINTER_LOW}, tp);
			wrt({2'h0, `DMAU_OFF_TABLE_POINTER_HIGH}, th);
			tbx(i[0], 1'b0);
		end
		// Broken patterns leave mapping off.
		unl(8'h5a, 1'b0);
		`CHK(act, 1'b0)
		unl(`DMAU_PATTERN_SECOND, 1'b1);
		`CHK(act, 1'b0)
		unl(`DMAU_PATTERN_SECOND, 1'b0);
		t0 = cyc;
		`CHK(act, 1'b1)
		v = xs();
		tp = `DMAU_OPT_BASE | v[7:0];
		th = v[15:8] & 8'hef;
		wrt({2'h0, `DMAU_OFF_TABLE_POINTER_LOW}, tp);
		wrt({2'h0, `DMAU_OFF_TABLE_POINTER_HIGH}, th);
		tbx(1'b1, 1'b1);
		tbx(1'b0, 1'b0);
		tp = tp & 8'h3f;
		wrt({2'h0, `DMAU_OFF_TABLE_POINTER_LOW}, tp);
		tbx(1'b1, 1'b0);
		// A repeated pattern restarts the window, which then closes by itself.
		while (cyc < t0 + 50) @(negedge clk);
		unl(`DMAU_PATTERN_SECOND, 1'b0);
		while (cyc < t0 + 140) @(negedge clk);
		`CHK(act, 1'b1)
		for (i = 0; i < 80 && act !== 1'b0; i++) @(negedge clk);
		`CHK(act, 1'b0)
		// Wake clears the unlock register.
		wrt({2'h0, `DMAU_OFF_UNLOCK}, `DMAU_PATTERN_FIRST);
		@(posedge clk);
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		rdv({2'h0, `DMAU_OFF_UNLOCK}, got);
		`CHK(got, `DMAU_REG_RESET)
		wrap_up();
	end
endmodule : test_data_memory_addressing_unit

// ---- verilog/dmau_map_timer.sv ----
// Option map window timer that counts periods of the synchronised low-speed oscillator.
`timescale 1ns/1ps
`include "dmau_defs.svh"

module dmau_map_timer
	import dmau_pkg::*;
(
	// Clock and reset.
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	// Oscillator pin and start pulse.
	input  wire logic       low_speed_internal_osc_i,
	input  wire logic       start_i,
	// Window state.
	output logic            active_o
);

	logic       sync1_reg;
	logic       sync2_reg;
	logic       sync3_reg;
	logic       level_reg;
	logic [2:0] count_reg;
	logic       stable;
	logic       rise;

	// Three-stage synchroniser for the oscillator pin.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			sync3_reg <= 1'b0;
		end else begin
			sync1_reg <= low_speed_internal_osc_i;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	// A level counts only when the second and third stages agree.
	assign stable = (sync2_reg == sync3_reg);
	assign rise   = stable & sync3_reg & ~level_reg;

	// Filtered oscillator level.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			level_reg <= 1'b0;
		end else if (stable) begin
			level_reg <= sync3_reg;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			active_o  <= 1'b0;
			count_reg <= 3'h0;
		end else if (start_i) begin
			active_o  <= 1'b1;
			count_reg <= 3'h0;
		end else if (active_o && rise) begin
			count_reg <= count_reg + 3'h1;
			if (count_reg == (`DMAU_LOW_SPEED_INTERNAL_OSC_PERIODS - 3'h1)) begin
				active_o <= 1'b0;
			end
		end
	end

	restart_zero_a: assert property (@(posedge clk_i) disable iff (reset_i)
		start_i |=> (active_o && count_reg == 3'h0))
		else $error("Window did not restart from zero.");

	expiry_end_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(active_o && rise && !start_i && count_reg == 3'h3) |=> !active_o)
		else $error("Window did not close after four periods.");

	// Window never stays open past four periods.
	count_bound_a: assert property (@(posedge clk_i) disable iff (reset_i)
		count_reg <= `DMAU_LOW_SPEED_INTERNAL_OSC_PERIODS)
		else $error("Window period count overran.");

	window_expires_c: cover property (@(posedge clk_i) disable iff (reset_i)
		$fell(active_o));

endmodule : dmau_map_timer

// ---- verilog/dmau_top.sv ----
// Data memory addressing unit: pointers, indirect ports, jumps, table reads, option map.
`timescale 1ns/1ps
`include "dmau_defs.svh"

module dmau_top
	import dmau_pkg::*;
(
	// Clock and reset.
	input  wire logic        CLK_I,
	input  wire logic        RESET_I,
	// Core instruction timing and wake event.
	input  wire logic        INSTR_STROBE_I,
	input  wire logic        WAKE_I,
	// Core data access.
	input  wire logic [9:0]  DM_ADDR_I,
	input  wire logic        DM_RD_I,
	input  wire logic        DM_WR_I,
	input  wire logic [7:0]  DM_WDATA_I,
	output logic      [7:0]  DM_RDATA_O,
	output logic             DM_RVALID_O,
	// Data RAM port.
	output logic      [9:0]  RAM_ADDR_O,
	output logic             RAM_RD_O,
	output logic             RAM_WR_O,
	output logic      [7:0]  RAM_WDATA_O,
	input  wire logic [7:0]  RAM_RDATA_I,
	// Program counter low byte.
	input  wire logic [7:0]  PC_LOW_I,
	output logic             JUMP_O,
	output logic      [7:0]  JUMP_LOW_O,
	output logic             DUMMY_CYCLE_O,
	// Table read request and result.
	input  wire logic        TBL_RD_I,
	input  wire logic        TBL_LAST_PAGE_I,
	output logic      [7:0]  TBL_LOW_O,
	output logic             TBL_DONE_O,
	// Program and option memory.
	output logic      [12:0] PM_ADDR_O,
	output logic             PM_RD_O,
	input  wire logic [15:0] PM_RDATA_I,
	output logic      [5:0]  OPT_ADDR_O,
	output logic             OPT_RD_O,
	input  wire logic [15:0] OPT_RDATA_I,
	// Low-speed oscillator and mapping state.
	input  wire logic        LOW_SPEED_INTERNAL_OSC_I,
	output logic             MAP_ACTIVE_O
);

	// ****************************************************************
	// Declarations.
	// ****************************************************************
	logic [7:0]         stored_reg [0:`DMAU_NUM_STORED-1];
	logic [7:0]         table_high_latch_reg;
	logic               arm_reg;
	logic               map_start_reg;
	logic               rd1_reg;
	logic               rd1_local_reg;
	logic [7:0]         rd1_data_reg;
	logic               rd2_reg;
	logic               rd2_local_reg;
	logic [7:0]         rd2_data_reg;
	logic               src_opt_reg;
	dmau_tbl_state_type state_reg;
	dmau_tbl_state_type state_next;

	wire                sec_zero;
	wire                hit_ind0;
	wire                hit_ind1;
	wire                hit_ind2;
	wire [9:0]          eff_addr;
	wire                eff_zero;
	wire [7:0]          eff_off;
	wire                eff_is_ind;
	wire                hit_pcl;
	wire                hit_table_high_latch;
	wire                lhit;
	wire [2:0]          lidx;
	wire                local_sel;
	wire                ram_sel;
	wire [7:0]          local_rdata;
	wire                wr_unlock;
	wire                arm_next;
	wire                start_next;
	wire [4:0]          tbl_page;
	wire                opt_hit;
	wire [15:0]         fetch_word;

	// ****************************************************************
	// Address resolution.
	// ****************************************************************

	assign sec_zero = (DM_ADDR_I[9:8] == `DMAU_SECTOR_ZERO);
	assign hit_ind0 = sec_zero & (DM_ADDR_I[7:0] == `DMAU_OFF_IND0);
	assign hit_ind1 = sec_zero & (DM_ADDR_I[7:0] == `DMAU_OFF_IND1);
	assign hit_ind2 = sec_zero & (DM_ADDR_I[7:0] == `DMAU_OFF_IND2);
	assign eff_addr = hit_ind0 ? {`DMAU_SECTOR_ZERO, stored_reg[`DMAU_IDX_PTR0]} :
	                  hit_ind1 ? {stored_reg[`DMAU_IDX_PTR1H][1:0], stored_reg[`DMAU_IDX_PTR1L]} :
	                  hit_ind2 ? {stored_reg[`DMAU_IDX_PTR2H][1:0], stored_reg[`DMAU_IDX_PTR2L]} :
	                  DM_ADDR_I;

	assign eff_zero   = (eff_addr[9:8] == `DMAU_SECTOR_ZERO);
	assign eff_off    = eff_addr[7:0];
	assign eff_is_ind = eff_zero & ((eff_off == `DMAU_OFF_IND0) | (eff_off == `DMAU_OFF_IND1) |
	                                (eff_off == `DMAU_OFF_IND2));

	// Decode of the locally held registers.
	assign hit_pcl  = eff_zero & (eff_off == `DMAU_OFF_PCL);
	assign hit_table_high_latch = eff_zero & (eff_off == `DMAU_OFF_TABLE_HIGH_LATCH);
	assign lhit     = eff_zero & ((eff_off == `DMAU_OFF_PTR0) | (eff_off == `DMAU_OFF_PTR1L) |
	                  (eff_off == `DMAU_OFF_PTR1H) | (eff_off == `DMAU_OFF_PTR2L) |
	                  (eff_off == `DMAU_OFF_PTR2H) | (eff_off == `DMAU_OFF_TABLE_POINTER_LOW) |
	                  (eff_off == `DMAU_OFF_TABLE_POINTER_HIGH) | (eff_off == `DMAU_OFF_UNLOCK));
	assign lidx = (eff_off == `DMAU_OFF_PTR0)  ? `DMAU_IDX_PTR0  :
	              (eff_off == `DMAU_OFF_PTR1L) ? `DMAU_IDX_PTR1L :
	              (eff_off == `DMAU_OFF_PTR1H) ? `DMAU_IDX_PTR1H :
	              (eff_off == `DMAU_OFF_PTR2L) ? `DMAU_IDX_PTR2L :
	              (eff_off == `DMAU_OFF_PTR2H) ? `DMAU_IDX_PTR2H :
	              (eff_off == `DMAU_OFF_TABLE_POINTER_LOW)  ? `DMAU_IDX_TABLE_POINTER_LOW  :
	              (eff_off == `DMAU_OFF_TABLE_POINTER_HIGH)  ? `DMAU_IDX_TABLE_POINTER_HIGH  : `DMAU_IDX_UNLOCK;

	assign local_sel   = lhit | hit_pcl | hit_table_high_latch | eff_is_ind;
	assign ram_sel     = ~local_sel;
	assign local_rdata = lhit     ? stored_reg[lidx] :
	                     hit_pcl  ? PC_LOW_I :
	                     hit_table_high_latch ? table_high_latch_reg : `DMAU_READ_ZERO;

	// ****************************************************************
	// Stored registers.
	// ****************************************************************

	genvar gi;
	generate
		for (gi = 0; gi < `DMAU_NUM_STORED; gi = gi + 1) begin : g_stored
			always_ff @(posedge CLK_I) begin
				if (RESET_I) begin
					stored_reg[gi] <= `DMAU_REG_RESET;
				end else if (WAKE_I && (gi == `DMAU_IDX_UNLOCK)) begin
					stored_reg[gi] <= `DMAU_REG_RESET;
				end else if (DM_WR_I && lhit && (lidx == gi)) begin
					stored_reg[gi] <= DM_WDATA_I;
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Data access pipeline.
	// ****************************************************************

	// Forward RAM accesses and stage local reads.
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			RAM_ADDR_O    <= 10'h000;
			RAM_RD_O      <= 1'b0;
			RAM_WR_O      <= 1'b0;
			RAM_WDATA_O   <= 8'h00;
			rd1_reg       <= 1'b0;
			rd1_local_reg <= 1'b0;
			rd1_data_reg  <= 8'h00;
		end else begin
			RAM_ADDR_O    <= eff_addr;
			RAM_RD_O      <= DM_RD_I & ram_sel;
			RAM_WR_O      <= DM_WR_I & ram_sel;
			RAM_WDATA_O   <= DM_WDATA_I;
			rd1_reg       <= DM_RD_I;
			rd1_local_reg <= local_sel;
			rd1_data_reg  <= local_rdata;
		end
	end

	// Wait for RAM data, then return the read result.
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			rd2_reg       <= 1'b0;
			rd2_local_reg <= 1'b0;
			rd2_data_reg  <= 8'h00;
			DM_RDATA_O    <= 8'h00;
			DM_RVALID_O   <= 1'b0;
		end else begin
			rd2_reg       <= rd1_reg;
			rd2_local_reg <= rd1_local_reg;
			rd2_data_reg  <= rd1_data_reg;
			DM_RDATA_O    <= rd2_local_reg ? rd2_data_reg : RAM_RDATA_I;
			DM_RVALID_O   <= rd2_reg;
		end
	end

	// ****************************************************************
	// Program counter low byte jump.
	// ****************************************************************

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			JUMP_O        <= 1'b0;
			JUMP_LOW_O    <= 8'h00;
			DUMMY_CYCLE_O <= 1'b0;
		end else begin
			JUMP_O        <= DM_WR_I & hit_pcl;
			DUMMY_CYCLE_O <= JUMP_O;
			if (DM_WR_I && hit_pcl) begin
				JUMP_LOW_O <= DM_WDATA_I;
			end
		end
	end

	// ****************************************************************
	// Unlock pattern detection.
	// ****************************************************************

	assign wr_unlock  = DM_WR_I & lhit & (lidx == `DMAU_IDX_UNLOCK);
	assign arm_next   = wr_unlock & (DM_WDATA_I == `DMAU_PATTERN_FIRST);
	assign start_next = arm_reg & wr_unlock & (DM_WDATA_I == `DMAU_PATTERN_SECOND);

	// Each instruction cycle re-evaluates the pending pattern.
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			arm_reg       <= 1'b0;
			map_start_reg <= 1'b0;
		end else begin
			map_start_reg <= INSTR_STROBE_I & start_next;
			if (INSTR_STROBE_I) begin
				arm_reg <= arm_next;
			end
		end
	end

	dmau_map_timer u_timer (
		.clk_i    (CLK_I),
		.reset_i  (RESET_I),
		.low_speed_internal_osc_i   (LOW_SPEED_INTERNAL_OSC_I),
		.start_i  (map_start_reg),
		.active_o (MAP_ACTIVE_O)
	);

	// ****************************************************************
	// Table read sequencer.
	// ****************************************************************

	assign tbl_page   = TBL_LAST_PAGE_I ? `DMAU_LAST_PAGE : stored_reg[`DMAU_IDX_TABLE_POINTER_HIGH][4:0];
	assign opt_hit    = MAP_ACTIVE_O & (tbl_page == `DMAU_LAST_PAGE) &
	                    (stored_reg[`DMAU_IDX_TABLE_POINTER_LOW] >= `DMAU_OPT_BASE);
	assign fetch_word = src_opt_reg ? OPT_RDATA_I : PM_RDATA_I;
	assign state_next = ((state_reg == TBL_IDLE) && TBL_RD_I) ? TBL_FETCH : TBL_IDLE;

	// Issue the fetch, then latch the word one cycle later.
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			state_reg   <= TBL_IDLE;
			PM_ADDR_O   <= 13'h0000;
			PM_RD_O     <= 1'b0;
			OPT_ADDR_O  <= 6'h00;
			OPT_RD_O    <= 1'b0;
			src_opt_reg <= 1'b0;
			table_high_latch_reg    <= `DMAU_REG_RESET;
			TBL_LOW_O   <= 8'h00;
			TBL_DONE_O  <= 1'b0;
		end else begin
			state_reg  <= state_next;
			PM_RD_O    <= 1'b0;
			OPT_RD_O   <= 1'b0;
			TBL_DONE_O <= 1'b0;
			case (state_reg)
				TBL_IDLE: begin
					if (TBL_RD_I) begin
						src_opt_reg <= opt_hit;
						PM_RD_O     <= ~opt_hit;
						OPT_RD_O    <= opt_hit;
						PM_ADDR_O   <= {tbl_page, stored_reg[`DMAU_IDX_TABLE_POINTER_LOW]};
						OPT_ADDR_O  <= stored_reg[`DMAU_IDX_TABLE_POINTER_LOW][5:0];
					end
				end
				TBL_FETCH: begin
					table_high_latch_reg   <= fetch_word[15:8];
					TBL_LOW_O  <= fetch_word[7:0];
					TBL_DONE_O <= 1'b1;
				end
				default: begin
					table_high_latch_reg <= table_high_latch_reg;
				end
			endcase
		end
	end

	// ****************************************************************
	// Checks.
	// ****************************************************************
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RESET_I);

	ind_read_zero_a: assert property ((DM_RD_I && eff_is_ind) |-> ##3
		(DM_RVALID_O && DM_RDATA_O == 8'h00)) else $error("Indirect port read not zero.");
	ind_write_nop_a: assert property ((DM_WR_I && eff_is_ind) |=> !RAM_WR_O)
		else $error("Indirect port write reached RAM.");
	ptr0_redirect_a: assert property ((DM_RD_I && hit_ind0 && ram_sel) |=>
		(RAM_RD_O && RAM_ADDR_O == {2'h0, $past(stored_reg[0])}))
		else $error("Port zero not redirected into sector zero.");
	ptr1_sector_a: assert property ((DM_WR_I && hit_ind1 && ram_sel) |=>
		(RAM_WR_O && RAM_ADDR_O == {$past(stored_reg[2][1:0]), $past(stored_reg[1])}))
		else $error("Port one sector or offset wrong.");
	ptr_store_a: assert property ((DM_WR_I && lhit && !WAKE_I) |=>
		(stored_reg[$past(lidx)] == $past(DM_WDATA_I))) else $error("Pointer write lost.");
	ext_direct_a: assert property ((DM_WR_I && !hit_ind0 && !hit_ind1 && !hit_ind2 && ram_sel)
		|=> (RAM_WR_O && RAM_ADDR_O == $past(DM_ADDR_I)))
		else $error("Extended address not passed through.");
	pcl_jump_a: assert property ((DM_WR_I && hit_pcl) |=>
		(JUMP_O && JUMP_LOW_O == $past(DM_WDATA_I))) else $error("Low-byte jump missing.");
	dummy_cycle_a: assert property ((DM_WR_I && hit_pcl) |=> ##1 DUMMY_CYCLE_O)
		else $error("Dummy cycle not inserted.");
	tbl_fetch_a: assert property ((state_reg == TBL_IDLE && TBL_RD_I && !opt_hit) |=>
		(PM_RD_O && PM_ADDR_O == {$past(tbl_page), $past(stored_reg[5])}))
		else $error("Table address not from table pointers.");
	tbl_latch_a: assert property (PM_RD_O |=>
		(TBL_DONE_O && table_high_latch_reg == $past(PM_RDATA_I[15:8]) && TBL_LOW_O == $past(PM_RDATA_I[7:0])))
		else $error("Table bytes not split correctly.");
	unlock_start_a: assert property (map_start_reg |=> MAP_ACTIVE_O)
		else $error("Good pattern did not open mapping.");
	bad_pattern_a: assert property ((INSTR_STROBE_I && !start_next) |=> !map_start_reg)
		else $error("Bad pattern started mapping.");
	opt_map_a: assert property ((state_reg == TBL_IDLE && TBL_RD_I && opt_hit) |=>
		(OPT_RD_O && !PM_RD_O && OPT_ADDR_O == $past(stored_reg[5][5:0])))
		else $error("Option word not mapped.");
	wake_clear_a: assert property (WAKE_I |=> stored_reg[7] == 8'h00)
		else $error("Wake did not clear unlock register.");
	single_access_a: assert property (!(RAM_RD_O && RAM_WR_O))
		else $error("Two RAM operations at once.");

	unlock_ok_c: cover property (map_start_reg ##1 MAP_ACTIVE_O);
	opt_read_c: cover property (OPT_RD_O ##1 TBL_DONE_O);
	ind_access_c: cover property (DM_RD_I && hit_ind1 && ram_sel);
	pcl_jump_c: cover property (JUMP_O ##1 DUMMY_CYCLE_O);

endmodule : dmau_top
